/* File: src/pll_ctrl_defs.vh */
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the top design file of the synthesizer control block; the divider and timer files do not include it
`ifndef PLL_CTRL_DEFS_VH
`define PLL_CTRL_DEFS_VH
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_LDDLY 8'h04
`define OFS_NINT 8'h08
`define OFS_NUM 8'h0C
`define OFS_DEN 8'h10
`define OFS_PFD 8'h14
`define OFS_VCO 8'h18
`define OFS_FORCE 8'h1C
`define OFS_STAT 8'h20
// Control word fields
`define CTRL_FCAL 0
`define CTRL_QUICK 1
`define CTRL_DIV_LO 2
`define CTRL_DIV_HI 3
`define CTRL_ORD_LO 4
`define CTRL_ORD_HI 6
`define CTRL_PINSEL 7
`define CTRL_LDKIND 8
`define CTRL_MUTE 9
// Oscillator start fields
`define VCO_CORE_LO 0
`define VCO_CORE_HI 2
`define VCO_BAND_LO 8
`define VCO_BAND_HI 15
`define VCO_AMP_LO 16
`define VCO_AMP_HI 24
`define VCO_FCORE 28
`define VCO_FAMP 29
`define VCO_FBAND 30
// Forced value fields
`define FRC_BAND_LO 0
`define FRC_BAND_HI 7
`define FRC_AMP_LO 8
`define FRC_AMP_HI 16
// Reset values
`define RST_CTRL 32'h0000_0000
`define RST_LDDLY 16'h0000
`define RST_NINT 19'h0_0020
`define RST_DEN 32'h0000_0001
`define RST_PFD 3'h1
`define RST_CORE 3'h7
`define RST_BAND 8'hB7
`define RST_AMP 9'h12C
// Lock readback codes and modulator limits
`define LD_RB_LOCKED 2'h2
`define LD_RB_UNLOCKED 2'h0
`define MOD_MAX_ORDER 3'h4
// Calibration phase length in state-machine cycles
`define CAL_PHASE_TICKS 16'h0010
`endif

/* File: src/sm_clock_divider.v */
// State-machine tick: one pulse every 2**div_sel reference cycles
// Assumes clk_i is the reference input
`timescale 1ns/1ps
module sm_clock_divider (
  input wire clk_i,
  input wire rst_i,
  input wire [1:0] div_sel_i,
  output reg sm_tick_o
);
  reg [2:0] cnt;
  wire [2:0] mask;
  assign mask = (3'h1 << div_sel_i) - 3'h1;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 3'h0;
      sm_tick_o <= 1'b0;
    end else begin
      cnt <= cnt + 3'h1; // RULE_02
      sm_tick_o <= ((cnt & mask) == mask); // RULE_02
    end
  end
endmodule // sm_clock_divider

/* File: src/lockdet_delay_timer.v */
// Lock-detect delay counter in state-machine cycles
// Assumes start_i is a one-cycle pulse aligned to a tick
`timescale 1ns/1ps
module lockdet_delay_timer (
  input wire clk_i,
  input wire rst_i,
  input wire sm_tick_i,
  input wire start_i,
  input wire [15:0] delay_i,
  output reg busy_o
);
  reg [15:0] cnt;
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 16'h0000;
      busy_o <= 1'b0;
    end else if (start_i) begin
      cnt <= delay_i; // RULE_11
      busy_o <= (delay_i != 16'h0000);
    end else if (busy_o && sm_tick_i) begin
      cnt <= cnt - 16'h0001; // RULE_03
      if (cnt == 16'h0001) begin
        busy_o <= 1'b0;
      end
    end
  end
endmodule // lockdet_delay_timer

/* File: src/pll_cal_lockdetect_ctrl.v */
// Synthesizer digital control: registers, modulator, calibration, lock
// Assumes clk_i is the reference; Wishbone master on the same clock
// Function
// [RULE_01] Post divider input stays at most 250 MHz
// [RULE_02] State clock is reference over 1,2,4,8
// [RULE_03] Delay and calibration run on state clock
// [RULE_04] Division ratio is integer plus numerator/denominator
// [RULE_05] Modulator order zero to four
// [RULE_06] Control word write resets modulator state
// [RULE_07] Host keeps integer divide above minimum
// [RULE_08] Host sets detector delay per table row
// [RULE_09] Pin select: 0 readback, 1 lock
// [RULE_10] Lock kind: 0 calibration, 1 tuning voltage
// [RULE_11] Lock delay counts 0..65535 state cycles
// [RULE_12] Calibration lock low during cal and delay
// [RULE_13] Mute outputs while lock low if enabled
// [RULE_14] Tuning lock drives high, reads state 2
// [RULE_15] Control write with trigger starts band cal
// [RULE_16] Every control write runs amplitude cal; code skips it when all three override bits are set
// [RULE_17] Host supplies reference before triggering cal
// [RULE_18] Host default start core 7, 300, 183
// [RULE_19] Partial assist: host writes start values
// [RULE_20] Fast restart starts from present band code
// [RULE_21] All overrides use host values directly
// [RULE_22] Control write gives one state-clock pulse
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pll_ctrl_defs.vh"
module pll_cal_lockdetect_ctrl #(
  parameter [15:0] CAL_TICKS = `CAL_PHASE_TICKS
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire vtune_ok_i,
  output reg multi_function_pin_o,
  output reg rf_mute_o,
  output reg [19:0] feedback_div_o,
  output reg [2:0] detector_delay_sel_o,
  output reg [2:0] osc_core_choice_o,
  output reg [7:0] band_code_o,
  output reg [8:0] amp_setting_o,
  output reg mod_reset_o,
  output reg cal_busy_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_AMP = 3'b010;
  localparam ST_BAND = 3'b100;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        merge[k*8 +: 8] = sel[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
      end
    end
  endfunction

  function [32:0] acc_step;
    input [31:0] acc;
    input [31:0] inc;
    input [31:0] frac_denominator;
    reg [32:0] s;
    begin
      s = {1'b0, acc} + {1'b0, inc};
      if (frac_denominator != 32'h0000_0000 && s >= {1'b0, frac_denominator}) begin
        acc_step = {1'b1, s[31:0] - frac_denominator};
      end else begin
        acc_step = {1'b0, s[31:0]};
      end
    end
  endfunction

  function signed [5:0] b2s;
    input b;
    begin
      b2s = {5'b0_0000, b};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register file
  reg [31:0] ctrl;
  reg [15:0] lddly;
  reg [18:0] nint;
  reg [31:0] num;
  reg [31:0] frac_denominator;
  reg [2:0] pfd_sel;
  reg [31:0] vco_word;
  reg [31:0] force_word;
  reg [31:0] status;
  wire req;
  wire wr_en;
  wire [31:0] wr_ctrl;
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_en = req & wb_we_i & wb_ack_o;

  wire fcal_trigger = ctrl[`CTRL_FCAL];
  wire fast_restart_cal = ctrl[`CTRL_QUICK];
  wire [1:0] div_sel = ctrl[`CTRL_DIV_HI:`CTRL_DIV_LO];
  wire [2:0] ord_raw = ctrl[`CTRL_ORD_HI:`CTRL_ORD_LO];
  wire pin_function_select = ctrl[`CTRL_PINSEL];
  wire lockdet_kind = ctrl[`CTRL_LDKIND];
  wire mute_on_unlock = ctrl[`CTRL_MUTE];
  wire [2:0] core_start = vco_word[`VCO_CORE_HI:`VCO_CORE_LO];
  wire [7:0] band_start_code = vco_word[`VCO_BAND_HI:`VCO_BAND_LO];
  wire [8:0] amp_start_value = vco_word[`VCO_AMP_HI:`VCO_AMP_LO];
  wire core_override = vco_word[`VCO_FCORE];
  wire amp_override = vco_word[`VCO_FAMP];
  wire band_override = vco_word[`VCO_FBAND];
  wire [7:0] band_force = force_word[`FRC_BAND_HI:`FRC_BAND_LO];
  wire [8:0] amp_force = force_word[`FRC_AMP_HI:`FRC_AMP_LO];
  wire [2:0] modulator_order = (ord_raw > `MOD_MAX_ORDER) ? `MOD_MAX_ORDER : ord_raw; // RULE_05
  assign wr_ctrl = merge(ctrl, wb_dat_i, wb_sel_i);
  wire [31:0] wr_lddly = merge({16'h0000, lddly}, wb_dat_i, wb_sel_i);
  wire [31:0] wr_nint = merge({13'h0000, nint}, wb_dat_i, wb_sel_i);
  wire [31:0] wr_pfd = merge({29'h0000_0000, pfd_sel}, wb_dat_i, wb_sel_i);

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `RST_CTRL;
      lddly <= `RST_LDDLY;
      nint <= `RST_NINT;
      num <= 32'h0000_0000;
      frac_denominator <= `RST_DEN;
      pfd_sel <= `RST_PFD;
      vco_word <= {7'h00, `RST_AMP, `RST_BAND, 5'h00, `RST_CORE};
      force_word <= 32'h0000_0000;
    end else if (wr_en) begin
      if (wb_adr_i == `OFS_CTRL) begin
        ctrl <= {22'h00_0000, wr_ctrl[9:0]};
      end else if (wb_adr_i == `OFS_LDDLY) begin
        lddly <= wr_lddly[15:0]; // RULE_11
      end else if (wb_adr_i == `OFS_NINT) begin
        nint <= wr_nint[18:0];
      end else if (wb_adr_i == `OFS_NUM) begin
        num <= merge(num, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `OFS_DEN) begin
        frac_denominator <= merge(frac_denominator, wb_dat_i, wb_sel_i); // RULE_04
      end else if (wb_adr_i == `OFS_PFD) begin
        pfd_sel <= wr_pfd[2:0];
      end else if (wb_adr_i == `OFS_VCO) begin
        vco_word <= merge(vco_word, wb_dat_i, wb_sel_i) & 32'h71FF_FF07;
      end else if (wb_adr_i == `OFS_FORCE) begin
        force_word <= merge(force_word, wb_dat_i, wb_sel_i) & 32'h0001_FFFF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus answer, one cycle after the request
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (wb_adr_i == `OFS_CTRL) begin
        wb_dat_o <= ctrl;
      end else if (wb_adr_i == `OFS_LDDLY) begin
        wb_dat_o <= {16'h0000, lddly};
      end else if (wb_adr_i == `OFS_NINT) begin
        wb_dat_o <= {13'h0000, nint};
      end else if (wb_adr_i == `OFS_NUM) begin
        wb_dat_o <= num;
      end else if (wb_adr_i == `OFS_DEN) begin
        wb_dat_o <= frac_denominator;
      end else if (wb_adr_i == `OFS_PFD) begin
        wb_dat_o <= {29'h0000_0000, pfd_sel};
      end else if (wb_adr_i == `OFS_VCO) begin
        wb_dat_o <= vco_word;
      end else if (wb_adr_i == `OFS_FORCE) begin
        wb_dat_o <= force_word;
      end else if (wb_adr_i == `OFS_STAT) begin
        wb_dat_o <= status;
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State-machine tick and control-write pulse
  wire sm_tick;
  reg r0_pending;
  reg r0_pulse;
  sm_clock_divider u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .div_sel_i(div_sel),
    .sm_tick_o(sm_tick)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      r0_pending <= 1'b0;
      r0_pulse <= 1'b0;
    end else begin
      r0_pending <= (wr_en && wb_adr_i == `OFS_CTRL) | (r0_pending & ~sm_tick); // RULE_22
      r0_pulse <= r0_pending & sm_tick; // RULE_22
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fractional modulator, cascaded accumulators
  reg [31:0] acc [0:3];
  reg [31:0] next_acc [0:3];
  reg [3:0] cy;
  reg h2;
  reg [1:0] h3;
  reg [2:0] h4;
  reg signed [5:0] offs;
  reg [32:0] st;
  reg [31:0] inc;
  integer i;
  integer j;

  always @* begin
    st = 33'h0_0000_0000;
    inc = 32'h0000_0000;
    cy = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      inc = (i == 0) ? num : next_acc[i-1];
      st = acc_step(acc[i], inc, frac_denominator); // RULE_04
      next_acc[i] = st[31:0];
      cy[i] = st[32];
    end
    offs = 6'sd0;
    if (modulator_order >= 3'h1) begin
      offs = b2s(cy[0]);
    end
    if (modulator_order >= 3'h2) begin
      offs = offs + b2s(cy[1]) - b2s(h2);
    end
    if (modulator_order >= 3'h3) begin
      offs = offs + b2s(cy[2]) - b2s(h3[0]) - b2s(h3[0]) + b2s(h3[1]);
    end
    if (modulator_order >= 3'h4) begin
      offs = offs + b2s(cy[3]) - 6'sd3 * b2s(h4[0]) + 6'sd3 * b2s(h4[1]) - b2s(h4[2]);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i || r0_pulse) begin
      for (j = 0; j < 4; j = j + 1) begin
        acc[j] <= 32'h0000_0000; // RULE_06
      end
      h2 <= 1'b0;
      h3 <= 2'h0;
      h4 <= 3'h0;
      feedback_div_o <= {1'b0, nint};
    end else begin
      if (modulator_order != 3'h0) begin
        for (j = 0; j < 4; j = j + 1) begin
          acc[j] <= next_acc[j];
        end
      end
      h2 <= cy[1];
      h3 <= {h3[0], cy[2]};
      h4 <= {h4[1:0], cy[3]};
      feedback_div_o <= {1'b0, nint} + {{14{offs[5]}}, offs}; // RULE_04
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator calibration sequencer
  reg [2:0] state;
  reg [15:0] phase_cnt;
  reg cal_done;
  reg cal_seen;
  wire all_force = core_override & amp_override & band_override;
  wire phase_end = sm_tick && (phase_cnt == CAL_TICKS - 16'h0001);

  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      phase_cnt <= 16'h0000;
      cal_done <= 1'b0;
      cal_seen <= 1'b0;
      osc_core_choice_o <= `RST_CORE;
      band_code_o <= `RST_BAND;
      amp_setting_o <= `RST_AMP;
    end else begin
      cal_done <= 1'b0;
      if (r0_pulse) begin
        osc_core_choice_o <= core_start;
        phase_cnt <= 16'h0000;
        if (all_force) begin
          band_code_o <= band_force; // RULE_21
          amp_setting_o <= amp_force; // RULE_21
          state <= ST_IDLE;
          cal_done <= 1'b1;
          cal_seen <= 1'b1;
        end else begin
          band_code_o <= fast_restart_cal ? band_code_o : band_start_code; // RULE_20
          amp_setting_o <= amp_start_value; // RULE_20
          state <= ST_AMP; // RULE_16
        end
      end else begin
        case (state)
          ST_AMP: begin
            phase_cnt <= sm_tick ? phase_cnt + 16'h0001 : phase_cnt; // RULE_03
            if (phase_end) begin
              phase_cnt <= 16'h0000;
              if (fcal_trigger) begin
                state <= ST_BAND; // RULE_15
              end else begin
                state <= ST_IDLE;
                cal_done <= 1'b1;
                cal_seen <= 1'b1;
              end
            end
          end
          ST_BAND: begin
            phase_cnt <= sm_tick ? phase_cnt + 16'h0001 : phase_cnt; // RULE_03
            if (phase_end) begin
              phase_cnt <= 16'h0000;
              state <= ST_IDLE;
              cal_done <= 1'b1;
              cal_seen <= 1'b1;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lock detection
  wire delay_busy;
  reg vt_s1;
  reg vt_s2;
  reg lock_now;
  lockdet_delay_timer u_ld (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sm_tick_i(sm_tick),
    .start_i(cal_done),
    .delay_i(lddly),
    .busy_o(delay_busy)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      vt_s1 <= 1'b0;
      vt_s2 <= 1'b0;
    end else begin
      vt_s1 <= vtune_ok_i;
      vt_s2 <= vt_s1;
    end
  end

  always @* begin
    if (lockdet_kind) begin
      lock_now = vt_s2; // RULE_10 RULE_14
    end else begin
      lock_now = cal_seen & (state == ST_IDLE) & ~delay_busy & ~cal_done & ~r0_pulse; // RULE_10 RULE_12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Readback shift, pin and status
  reg [31:0] rb_shift;
  reg [4:0] rb_cnt;
  wire [1:0] lockdet_readback = lock_now ? `LD_RB_LOCKED : `LD_RB_UNLOCKED; // RULE_14

  always @(posedge clk_i) begin
    if (rst_i) begin
      rb_shift <= 32'h0000_0000;
      rb_cnt <= 5'h00;
      status <= 32'h0000_0000;
      multi_function_pin_o <= 1'b0;
      rf_mute_o <= 1'b0;
      mod_reset_o <= 1'b0;
      cal_busy_o <= 1'b0;
      detector_delay_sel_o <= `RST_PFD;
    end else begin
      status <= {4'h0, amp_setting_o, band_code_o, osc_core_choice_o, 4'h0, delay_busy,
                 state != ST_IDLE, lockdet_readback};
      if (sm_tick) begin
        rb_cnt <= rb_cnt + 5'h01;
        rb_shift <= (rb_cnt == 5'h00) ? status : {rb_shift[30:0], 1'b0};
      end
      multi_function_pin_o <= pin_function_select ? lock_now : rb_shift[31]; // RULE_09
      rf_mute_o <= mute_on_unlock & ~lock_now; // RULE_13
      mod_reset_o <= r0_pulse; // RULE_06
      cal_busy_o <= (state != ST_IDLE);
      detector_delay_sel_o <= pfd_sel;
    end
  end
endmodule // pll_cal_lockdetect_ctrl

/* File: testbench/pll_ctrl_props.sv */
// Port checker for the synthesizer control block
// Assumes binding to the top module; one clock, sync reset
`timescale 1ns/1ps
module pll_ctrl_props (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [2:0] detector_delay_sel_o,
  input wire mod_reset_o,
  input wire cal_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i;
  wire wr = wb_ack_o && req && wb_we_i && wb_sel_i[0];
  ////////////////////////////////////////////////////////////////
  property p_ack_next;
    req && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_unmapped;
    req && !wb_ack_o && !wb_we_i && wb_adr_i > 8'h20 |=> wb_dat_o == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_dly_sel;
    wr && wb_adr_i == 8'h14 |=> ##1 detector_delay_sel_o == $past(wb_dat_i[2:0], 2); endproperty
  a_dly_sel: assert property (p_dly_sel) else $error("delay select not copied");
  property p_mrst_pulse;
    mod_reset_o |=> !mod_reset_o; endproperty
  a_mrst_pulse: assert property (p_mrst_pulse) else $error("modulator reset too long");
  property p_mrst_after;
    wr && wb_adr_i == 8'h00 |-> ##[1:12] mod_reset_o; endproperty
  a_mrst_after: assert property (p_mrst_after) else $error("no modulator reset");
  property p_busy_src;
    $rose(cal_busy_o) |-> mod_reset_o || $past(mod_reset_o) || $past(mod_reset_o, 2); endproperty
  a_busy_src: assert property (p_busy_src) else $error("calibration without write");
  property p_busy_end;
    $rose(cal_busy_o) |-> ##[1:80] !cal_busy_o; endproperty
  a_busy_end: assert property (p_busy_end) else $error("calibration too long");
endmodule // pll_ctrl_props

/* File: testbench/tb_top.sv */
// Self-checking bench for the synthesizer control block
// Assumes design sources in src and the checker file compiled first
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, vtune_ok_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  wire [31:0] wb_dat_o;
  wire [19:0] feedback_div_o;
  wire [2:0] detector_delay_sel_o, osc_core_choice_o;
  wire [7:0] band_code_o;
  wire [8:0] amp_setting_o;
  wire wb_ack_o, multi_function_pin_o, rf_mute_o, mod_reset_o, cal_busy_o;
  integer miscompares = 0, samples_checked = 0, seed = 32'h0000_560e;
  integer c, bc, lc, bad, nb;
  logic [31:0] rd, t, n, m, s, rv;
  pll_cal_lockdetect_ctrl #(.CAL_TICKS(16'h0002)) i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .vtune_ok_i, .multi_function_pin_o, .rf_mute_o,
    .feedback_div_o, .detector_delay_sel_o, .osc_core_choice_o, .band_code_o, .amp_setting_o, .mod_reset_o,
    .cal_busy_o);
  initial forever #4 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] sl);
    integer i;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= sl;
    wb_dat_i <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 50);
    chk("bus ack", 1, wb_ack_o);
    if (wb_ack_o !== 1'b1) summarize();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    chk(nm, e, rd);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("core", 3'h7, osc_core_choice_o);
    chk("band", 8'hb7, band_code_o);
    chk("amp", 9'h12c, amp_setting_o);
    rchk("den", 8'h10, 32'h0000_0001);
    rchk("nint", 8'h08, 32'h0000_0020);
    wr(8'h40, 32'hffff_ffff);
    rchk("unmapped", 8'h40, 32'h0000_0000);
    wr(8'h0c, 32'hffff_ffff);
    bus(1'b1, 8'h0c, 32'h1234_5678, 4'h5);
    rchk("byte merge", 8'h0c, 32'hff34_ff78);
    m = {$random(seed)} % 6 + 1;
    wr(8'h14, m);
    repeat (2) @(posedge clk_i);
    chk("delay sel", m, detector_delay_sel_o);
    for (int o = 0; o < 5; o++) begin
      n = 28 + {$random(seed)} % 400;
      wr(8'h08, n);
      wr(8'h0c, 32'h0000_0000);
      wr(8'h00, o << 4);
      repeat (20) @(posedge clk_i);
      chk("int div", n, feedback_div_o);
    end
    t = 2 + {$random(seed)} % 15;
    m = {$random(seed)} % t;
    wr(8'h10, t);
    wr(8'h0c, m);
    wr(8'h00, 32'h0000_0010);
    repeat (20) @(posedge clk_i);
    s = 0;
    repeat (t) begin
      @(posedge clk_i);
      s += feedback_div_o;
    end
    chk("frac sum", n * t + m, s);
    wr(8'h00, 32'h0000_0040);
    repeat (20) @(posedge clk_i);
    s = 0;
    repeat (4 * t) begin
      @(posedge clk_i);
      s += feedback_div_o;
    end
    chk("mash4 mean", 1, s + 7 >= (n * t + m) * 4 && s <= (n * t + m) * 4 + 7);
    for (int d = 0; d < 4; d++) begin
      t = (d == 0) ? 0 : {$random(seed)} % 12;
      nb = (2 * (1 + d % 2)) << d;
      wr(8'h04, t);
      wr(8'h00, 32'h0000_0280 | d << 2 | d % 2);
      c = 0;
      bc = 0;
      lc = 0;
      bad = 0;
      while (c < 400 && !(bc > 0 && multi_function_pin_o === 1'b1)) begin
        @(posedge clk_i);
        c++;
        if (cal_busy_o === 1'b1 && bc > 1 && (multi_function_pin_o !== 1'b0 || rf_mute_o !== 1'b1)) bad++;
        if (cal_busy_o === 1'b1) bc++;
        else if (bc > 0) lc++;
      end
      chk("lock wait", 1, c < 400);
      if (c >= 400) summarize();
      chk("busy len", 1, bc + (1 << d) >= nb && bc <= nb + (1 << d) + 2);
      chk("lock delay", 1, lc >= (t << d) && lc <= ((t + 2) << d) + 4);
      chk("pin low in cal", 0, bad);
      repeat (3) @(posedge clk_i);
      chk("mute off", 0, rf_mute_o);
    end
    wr(8'h00, 32'h0000_0380);
    for (int v = 0; v < 2; v++) begin
      vtune_ok_i <= v[0];
      repeat (6) @(posedge clk_i);
      chk("vtune pin", v, multi_function_pin_o);
      chk("mute", !v, rf_mute_o);
      bus(1'b0, 8'h20, 32'h0000_0000, 4'hf);
      chk("lock code", v ? 2 : 0, rd[1:0]);
    end
    wr(8'h00, 32'h0000_0100);
    m = 0;
    bc = 0;
    repeat (40) begin
      @(posedge clk_i);
      m += !multi_function_pin_o;
      bc += multi_function_pin_o;
    end
    chk("readback", 1, m > 0);
    chk("readback ones", 1, bc > 0);
    rv = $random(seed) & 32'h01ff_ff07;
    wr(8'h18, rv);
    wr(8'h00, 32'h0000_0001);
    repeat (40) @(posedge clk_i);
    chk("start core", rv[2:0], osc_core_choice_o);
    chk("start band", rv[15:8], band_code_o);
    chk("start amp", rv[24:16], amp_setting_o);
    wr(8'h18, rv ^ 32'h0000_ff00);
    wr(8'h00, 32'h0000_0003);
    repeat (40) @(posedge clk_i);
    chk("fast band", rv[15:8], band_code_o);
    s = $random(seed) & 32'h0001_ffff;
    wr(8'h1c, s);
    wr(8'h18, rv | 32'h7000_0000);
    wr(8'h00, 32'h0000_0001);
    m = 0;
    repeat (12) begin
      @(posedge clk_i);
      m += cal_busy_o;
    end
    chk("forced busy", 0, m);
    chk("forced core", rv[2:0], osc_core_choice_o);
    chk("forced band", s[7:0], band_code_o);
    chk("forced amp", s[16:8], amp_setting_o);
    summarize();
  end
endmodule // tb_top
bind pll_cal_lockdetect_ctrl pll_ctrl_props i_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .detector_delay_sel_o, .mod_reset_o, .cal_busy_o);
